// ### inc/ewc_pkg.sv
// Shared constants and types for the encoder window comparator
package ewc_pkg;
   localparam int EWC_NUM_WIN = 2;
   localparam int EWC_NUM_AXES = 4;
   localparam int EWC_CW = 32;
   localparam int EWC_AXW = 2;
   localparam int EWC_TRIG_W = 4;
   localparam int EWC_TRIG_MODE_LSB = 0;
   localparam int EWC_TRIG_MODE_MSB = 1;
   localparam int EWC_TRIG_ARM_BIT = 2;
   localparam logic [EWC_AXW-1:0] EWC_AXIS_RST = 2'h0;
   localparam logic [EWC_CW-1:0] EWC_CNT_RST = 32'h0000_0000;
   localparam logic [EWC_CW-1:0] EWC_LOW_RST = 32'h0000_0000;
   localparam logic [EWC_CW-1:0] EWC_HIGH_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      EWC_TRIG_NONE  = 2'b00,
      EWC_TRIG_FIRST = 2'b01,
      EWC_TRIG_EVERY = 2'b10,
      EWC_TRIG_RSVD  = 2'b11
   } ewc_trig_t;

   typedef enum logic {
      EWC_GATE_RETAIN = 1'b0,
      EWC_GATE_INCR   = 1'b1
   } ewc_gate_t;
endpackage

// ### src/ewc_quad_dec.sv
// Quadrature decoder with full and half resolution counting
`timescale 1ns/10ps
module ewc_quad_dec
   import ewc_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Encoder phases
   input wire logic i_enc_a,
   input wire logic i_enc_b,
   // Control
   input wire logic i_half_resolution_decode,
   input wire logic i_resync,
   // Count events
   output logic o_step_up,
   output logic o_step_dn
);
   logic a_prev_ff, b_prev_ff, valid_ff;
   logic nxt_a_prev, nxt_b_prev, nxt_valid;
   logic a_chg, b_chg, step;

   always_comb begin
      nxt_a_prev = i_enc_a;
      nxt_b_prev = i_enc_b;
      nxt_valid = ~i_resync;
      a_chg = i_enc_a ^ a_prev_ff;
      b_chg = i_enc_b ^ b_prev_ff;
      // Two-edge decode counts only phase A edges
      if (i_half_resolution_decode) begin
         step = valid_ff & a_chg & ~b_chg;
      end else begin
         step = valid_ff & (a_chg ^ b_chg);
      end
      o_step_up = step & (i_enc_a ^ b_prev_ff);
      o_step_dn = step & ~(i_enc_a ^ b_prev_ff);
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         a_prev_ff <= 1'b0;
         b_prev_ff <= 1'b0;
         valid_ff <= 1'b0;
      end else begin
         a_prev_ff <= nxt_a_prev;
         b_prev_ff <= nxt_b_prev;
         valid_ff <= nxt_valid;
      end
   end
endmodule

// ### src/ewc_window_cmp.sv
// Two window comparators gating the position synchronised firing output
//
// Overview of operation
// - Two independent window units, each tracking its own selected axis encoder.
// - Each unit holds a loadable 32-bit up/down counter and low/high limits.
// - Counter and limits compare as signed two's-complement values.
// - Inside only when counter is strictly above low and strictly below high.
// - An enabled unit outside its window stops firing pulses.
// - Both units together form a two-dimensional gating window.
// - Both units disabled after reset; each enabled or disabled on its own.
// - Configuring a unit loads its counter with the supplied signed value.
// - Half-resolution option counts two edges per cycle and halves the load value.
// - Position retaining mode keeps the fire counter tracking while outside.
// - Incremental mode holds the fire counter reset while outside the window.
// - Gating mode persists until changed or reset; retaining mode after reset.
// - With marker triggering active, the marker forces the counter to zero.
// - Trigger 00 ignore, 01 hold until first edge, 10 every edge, 11 reserved.
// - First-edge mode releases only after the marker latch has been armed.
// - Trigger weight 4 arms the marker latch; clear leaves it untouched.
`timescale 1ns/10ps
module ewc_window_cmp
   import ewc_pkg::*;
#(
   parameter int NUM_AXES = EWC_NUM_AXES,
   parameter int CNT_W = EWC_CW
)
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Axis encoders
   input wire logic [NUM_AXES-1:0] i_enc_a,
   input wire logic [NUM_AXES-1:0] i_enc_b,
   input wire logic [NUM_AXES-1:0] i_enc_marker,
   // Window configuration, one strobe per unit
   input wire logic [EWC_NUM_WIN-1:0] i_cfg_wr,
   input wire logic [EWC_AXW-1:0] i_cfg_axis [EWC_NUM_WIN],
   input wire logic signed [CNT_W-1:0] i_cfg_load [EWC_NUM_WIN],
   input wire logic signed [CNT_W-1:0] i_cfg_low [EWC_NUM_WIN],
   input wire logic signed [CNT_W-1:0] i_cfg_high [EWC_NUM_WIN],
   input wire logic [EWC_NUM_WIN-1:0] i_cfg_enable,
   input wire logic [EWC_NUM_WIN-1:0] i_cfg_half_resolution_decode,
   input wire logic [EWC_TRIG_W-1:0] i_cfg_trigger [EWC_NUM_WIN],
   // Gating mode select strobes
   input wire logic i_sel_position_retaining_gating,
   input wire logic i_sel_incremental_gating,
   // Window status
   output logic signed [CNT_W-1:0] o_win_count [EWC_NUM_WIN],
   output logic [EWC_NUM_WIN-1:0] o_win_inside,
   output logic [EWC_NUM_WIN-1:0] o_win_enabled,
   output logic o_incremental_gating,
   // Towards the firing pulse generator
   output logic o_fire_permit,
   output logic o_fire_cnt_hold
);
   if (NUM_AXES < 1 || NUM_AXES > (1 << EWC_AXW)) begin : g_bad_axes
      $error("NUM_AXES must lie between 1 and 4");
   end
   if (CNT_W < 2) begin : g_bad_width
      $error("CNT_W must be at least 2");
   end

   // Picks the selected axis line, unused selections read low
   function automatic logic pick_axis(input logic [NUM_AXES-1:0] v,
                                      input logic [EWC_AXW-1:0] s);
      pick_axis = 1'b0;
      for (int i = 0; i < NUM_AXES; i++) begin
         if (s == i[EWC_AXW-1:0]) begin
            pick_axis = v[i];
         end
      end
   endfunction

   logic signed [CNT_W-1:0] cnt_ff [EWC_NUM_WIN];
   logic signed [CNT_W-1:0] nxt_cnt [EWC_NUM_WIN];
   logic signed [CNT_W-1:0] low_ff [EWC_NUM_WIN];
   logic signed [CNT_W-1:0] nxt_low [EWC_NUM_WIN];
   logic signed [CNT_W-1:0] high_ff [EWC_NUM_WIN];
   logic signed [CNT_W-1:0] nxt_high [EWC_NUM_WIN];
   logic signed [CNT_W-1:0] load_eff [EWC_NUM_WIN];
   logic [EWC_AXW-1:0] axis_ff [EWC_NUM_WIN];
   logic [EWC_AXW-1:0] nxt_axis [EWC_NUM_WIN];
   ewc_trig_t trig_ff [EWC_NUM_WIN];
   ewc_trig_t nxt_trig [EWC_NUM_WIN];
   logic [EWC_NUM_WIN-1:0] en_ff, nxt_en;
   logic [EWC_NUM_WIN-1:0] half_ff, nxt_half;
   logic [EWC_NUM_WIN-1:0] armed_ff, nxt_armed;
   logic [EWC_NUM_WIN-1:0] released_ff, nxt_released;
   logic [EWC_NUM_WIN-1:0] mark_prev_ff, nxt_mark_prev;
   logic [EWC_NUM_WIN-1:0] inside_ff, nxt_inside;
   logic [EWC_NUM_WIN-1:0] enc_a_sel, enc_b_sel, mark_sel, mark_edge;
   logic [EWC_NUM_WIN-1:0] step_up, step_dn, win_ok, held;
   ewc_gate_t gate_ff, nxt_gate;
   logic permit_ff, nxt_permit;
   logic hold_ff, nxt_hold;

   // One decoder per unit on its selected axis
   for (genvar w = 0; w < EWC_NUM_WIN; w++) begin : g_dec
      assign enc_a_sel[w] = pick_axis(i_enc_a, axis_ff[w]);
      assign enc_b_sel[w] = pick_axis(i_enc_b, axis_ff[w]);
      assign mark_sel[w] = pick_axis(i_enc_marker, axis_ff[w]);
      ewc_quad_dec u_dec (
         .i_mclk(i_mclk),
         .i_rst_b(i_rst_b),
         .i_enc_a(enc_a_sel[w]),
         .i_enc_b(enc_b_sel[w]),
         .i_half_resolution_decode(half_ff[w]),
         .i_resync(i_cfg_wr[w]),
         .o_step_up(step_up[w]),
         .o_step_dn(step_dn[w])
      );
   end

   // Window unit next state
   always_comb begin
      for (int w = 0; w < EWC_NUM_WIN; w++) begin
         nxt_cnt[w] = cnt_ff[w];
         nxt_low[w] = low_ff[w];
         nxt_high[w] = high_ff[w];
         nxt_axis[w] = axis_ff[w];
         nxt_trig[w] = trig_ff[w];
         nxt_en[w] = en_ff[w];
         nxt_half[w] = half_ff[w];
         nxt_armed[w] = armed_ff[w];
         nxt_released[w] = released_ff[w];
         nxt_mark_prev[w] = mark_sel[w];
         mark_edge[w] = mark_sel[w] & ~mark_prev_ff[w];
         held[w] = (trig_ff[w] == EWC_TRIG_FIRST) && !released_ff[w];
         if (i_cfg_half_resolution_decode[w]) begin
            load_eff[w] = i_cfg_load[w] >>> 1;
         end else begin
            load_eff[w] = i_cfg_load[w];
         end
         if (i_cfg_wr[w]) begin
            nxt_axis[w] = i_cfg_axis[w];
            nxt_cnt[w] = load_eff[w];
            nxt_low[w] = i_cfg_low[w];
            nxt_high[w] = i_cfg_high[w];
            nxt_en[w] = i_cfg_enable[w];
            nxt_half[w] = i_cfg_half_resolution_decode[w];
            nxt_trig[w] = ewc_trig_t'(i_cfg_trigger[w][EWC_TRIG_MODE_MSB:EWC_TRIG_MODE_LSB]);
            nxt_released[w] = 1'b0;
            if (i_cfg_trigger[w][EWC_TRIG_ARM_BIT]) begin
               nxt_armed[w] = 1'b1;
            end
         end else if (held[w] && mark_edge[w] && armed_ff[w]) begin
            nxt_released[w] = 1'b1;
            nxt_armed[w] = 1'b0;
            nxt_cnt[w] = EWC_CNT_RST;
         end else if (held[w]) begin
            nxt_cnt[w] = EWC_CNT_RST;
         end else if ((trig_ff[w] == EWC_TRIG_EVERY) && mark_edge[w]) begin
            nxt_cnt[w] = EWC_CNT_RST;
         end else if (step_up[w]) begin
            nxt_cnt[w] = CNT_W'(cnt_ff[w] + 1);
         end else if (step_dn[w]) begin
            nxt_cnt[w] = CNT_W'(cnt_ff[w] - 1);
         end
         nxt_inside[w] = (nxt_cnt[w] > nxt_low[w]) && (nxt_cnt[w] < nxt_high[w]);
         win_ok[w] = !en_ff[w] || (inside_ff[w] && !held[w]);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int w = 0; w < EWC_NUM_WIN; w++) begin
            cnt_ff[w] <= EWC_CNT_RST;
            low_ff[w] <= EWC_LOW_RST;
            high_ff[w] <= EWC_HIGH_RST;
            axis_ff[w] <= EWC_AXIS_RST;
            trig_ff[w] <= EWC_TRIG_NONE;
         end
         en_ff <= '0;
         half_ff <= '0;
         armed_ff <= '0;
         released_ff <= '0;
         mark_prev_ff <= '0;
         inside_ff <= '0;
      end else begin
         for (int w = 0; w < EWC_NUM_WIN; w++) begin
            cnt_ff[w] <= nxt_cnt[w];
            low_ff[w] <= nxt_low[w];
            high_ff[w] <= nxt_high[w];
            axis_ff[w] <= nxt_axis[w];
            trig_ff[w] <= nxt_trig[w];
         end
         en_ff <= nxt_en;
         half_ff <= nxt_half;
         armed_ff <= nxt_armed;
         released_ff <= nxt_released;
         mark_prev_ff <= nxt_mark_prev;
         inside_ff <= nxt_inside;
      end
   end

   // Gating mode and firing output next state
   always_comb begin
      nxt_gate = gate_ff;
      if (i_sel_position_retaining_gating) begin
         nxt_gate = EWC_GATE_RETAIN;
      end else if (i_sel_incremental_gating) begin
         nxt_gate = EWC_GATE_INCR;
      end
      nxt_permit = &win_ok;
      nxt_hold = (gate_ff == EWC_GATE_INCR) && !(&win_ok);
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         gate_ff <= EWC_GATE_RETAIN;
         permit_ff <= 1'b1;
         hold_ff <= 1'b0;
      end else begin
         gate_ff <= nxt_gate;
         permit_ff <= nxt_permit;
         hold_ff <= nxt_hold;
      end
   end

   assign o_win_count = cnt_ff;
   assign o_win_inside = inside_ff;
   assign o_win_enabled = en_ff;
   assign o_incremental_gating = (gate_ff == EWC_GATE_INCR);
   assign o_fire_permit = permit_ff;
   assign o_fire_cnt_hold = hold_ff;

   // Checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);

   for (genvar w = 0; w < EWC_NUM_WIN; w++) begin : g_chk
      load_value_a: assert property (i_cfg_wr[w] |=> cnt_ff[w] == $past(load_eff[w]))
         else $error("Window counter did not take the load value");
      inside_flag_a: assert property (inside_ff[w] == (cnt_ff[w] > low_ff[w] && cnt_ff[w] < high_ff[w]))
         else $error("Inside flag disagrees with strict limit compare");
      marker_every_a: assert property ((trig_ff[w] == EWC_TRIG_EVERY) && mark_edge[w] && !i_cfg_wr[w]
         |=> cnt_ff[w] == EWC_CNT_RST)
         else $error("Marker edge did not clear the window counter");
      first_hold_a: assert property (held[w] && !armed_ff[w] && !i_cfg_wr[w]
         |=> cnt_ff[w] == EWC_CNT_RST && !released_ff[w])
         else $error("Counter released without an armed marker edge");
      count_step_a: assert property ((trig_ff[w] == EWC_TRIG_NONE) && step_up[w] && !i_cfg_wr[w]
         |=> cnt_ff[w] == CNT_W'($past(cnt_ff[w]) + 1))
         else $error("Counter did not step up by one");
      arm_latch_a: assert property (i_cfg_wr[w] && i_cfg_trigger[w][EWC_TRIG_ARM_BIT] |=> armed_ff[w])
         else $error("Marker latch not armed by configuration");
      disabled_free_a: assert property (!en_ff[w] && !i_cfg_wr[w] |=> win_ok[w])
         else $error("Disabled window restricts firing");

      // Configuration capture
      axis_take_a: assert property (i_cfg_wr[w]
         |=> axis_ff[w] == $past(i_cfg_axis[w]))
         else $error("Axis select not taken from configuration");
      limit_take_a: assert property (i_cfg_wr[w]
         |=> low_ff[w] == $past(i_cfg_low[w]) && high_ff[w] == $past(i_cfg_high[w]))
         else $error("Window limits not taken from configuration");
      enable_take_a: assert property (i_cfg_wr[w]
         |=> en_ff[w] == $past(i_cfg_enable[w]))
         else $error("Window enable not taken from configuration");
      trig_take_a: assert property (i_cfg_wr[w]
         |=> trig_ff[w] == $past(i_cfg_trigger[w][EWC_TRIG_MODE_MSB:EWC_TRIG_MODE_LSB]))
         else $error("Trigger mode not taken from configuration");
      dec_resync_a: assert property (i_cfg_wr[w]
         |=> !step_up[w] && !step_dn[w])
         else $error("Encoder step taken in the cycle after configuration");

      // Counting and marker handling
      count_down_a: assert property ((trig_ff[w] == EWC_TRIG_NONE) && step_dn[w] && !i_cfg_wr[w]
         |=> cnt_ff[w] == CNT_W'($past(cnt_ff[w]) - 1))
         else $error("Counter did not step down by one");
      step_excl_a: assert property (!(step_up[w] && step_dn[w]))
         else $error("Decoder stepped both ways at once");
      mode_none_a: assert property ((trig_ff[w] == EWC_TRIG_NONE) && !i_cfg_wr[w]
         && !step_up[w] && !step_dn[w] |=> cnt_ff[w] == $past(cnt_ff[w]))
         else $error("Counter moved without a step or marker");
      first_release_a: assert property (held[w] && armed_ff[w] && mark_edge[w] && !i_cfg_wr[w]
         |=> released_ff[w] && !armed_ff[w] && cnt_ff[w] == EWC_CNT_RST)
         else $error("Armed marker edge did not release the counter");
      arm_keep_a: assert property (!i_cfg_wr[w] && !(held[w] && mark_edge[w])
         |=> armed_ff[w] == $past(armed_ff[w]))
         else $error("Marker latch changed without arm or release");

      // Firing gate per unit
      held_permit_a: assert property (held[w] && en_ff[w]
         |=> !o_fire_permit)
         else $error("Firing permitted before the first marker edge");
      outside_any_a: assert property (en_ff[w] && !inside_ff[w]
         |=> !o_fire_permit)
         else $error("Firing permitted while a unit is outside");
   end

   fire_permit_a: assert property (o_fire_permit == $past(&win_ok))
      else $error("Fire permit does not follow the window units");
   outside_stop_a: assert property (en_ff[0] && !inside_ff[0] |=> !o_fire_permit)
      else $error("Firing permitted while outside an enabled window");
   incr_hold_a: assert property ((gate_ff == EWC_GATE_INCR) && !(&win_ok) |=> o_fire_cnt_hold)
      else $error("Fire counter not held outside window in incremental mode");
   retain_track_a: assert property ((gate_ff == EWC_GATE_RETAIN) |=> !o_fire_cnt_hold)
      else $error("Fire counter held in position retaining mode");
   gate_persist_a: assert property (!i_sel_position_retaining_gating && !i_sel_incremental_gating
      |=> gate_ff == $past(gate_ff))
      else $error("Gating mode changed without a select");

   // Gating mode selects and combined firing gate
   retain_sel_a: assert property (i_sel_position_retaining_gating
      |=> gate_ff == EWC_GATE_RETAIN)
      else $error("Retaining select did not take effect");
   incr_sel_a: assert property (i_sel_incremental_gating && !i_sel_position_retaining_gating
      |=> gate_ff == EWC_GATE_INCR)
      else $error("Incremental select did not take effect");
   all_free_a: assert property (en_ff == '0
      |=> o_fire_permit)
      else $error("Firing blocked with both units disabled");
   both_inside_a: assert property ((&en_ff) && (&inside_ff) && !(|held)
      |=> o_fire_permit)
      else $error("Firing blocked with both units inside");
   hold_permit_a: assert property (o_fire_cnt_hold
      |-> !o_fire_permit)
      else $error("Fire counter held while firing permitted");
   incr_free_a: assert property ((gate_ff == EWC_GATE_INCR) && (&win_ok)
      |=> !o_fire_cnt_hold)
      else $error("Fire counter held while inside in incremental mode");

   both_inside_c: cover property (en_ff == 2'b11 && inside_ff == 2'b11 ##1 o_fire_permit);
   first_release_c: cover property (held[0] && armed_ff[0] && mark_edge[0] ##1 released_ff[0]);
   every_marker_c: cover property ((trig_ff[0] == EWC_TRIG_EVERY) && mark_edge[0]);
   incr_hold_c: cover property (o_incremental_gating && o_fire_cnt_hold);
   half_step_c: cover property (half_ff[0] && step_up[0]);
endmodule

// ### sim/ewc_enc_model.sv
// Quadrature encoder and marker model for the four axes
`timescale 1ns/10ps
module ewc_enc_model
   import ewc_pkg::*;
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Motion requests
   input wire logic [EWC_NUM_AXES-1:0] i_step_up,
   input wire logic [EWC_NUM_AXES-1:0] i_step_dn,
   input wire logic [EWC_NUM_AXES-1:0] i_mark,
   // Encoder lines
   output logic [EWC_NUM_AXES-1:0] o_enc_a,
   output logic [EWC_NUM_AXES-1:0] o_enc_b,
   output logic [EWC_NUM_AXES-1:0] o_enc_marker
);
   logic [1:0] phase_ff [EWC_NUM_AXES];
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < EWC_NUM_AXES; i++) begin
            phase_ff[i] <= 2'h0;
         end
      end else begin
         for (int i = 0; i < EWC_NUM_AXES; i++) begin
            if (i_step_up[i]) begin
               phase_ff[i] <= phase_ff[i] + 2'h1;
            end else if (i_step_dn[i]) begin
               phase_ff[i] <= phase_ff[i] - 2'h1;
            end
         end
      end
   end
   // Gray sequence 00, 10, 11, 01 when moving up: A leads B
   always_comb begin
      for (int i = 0; i < EWC_NUM_AXES; i++) begin
         o_enc_a[i] = phase_ff[i][1] ^ phase_ff[i][0];
         o_enc_b[i] = phase_ff[i][1];
      end
   end
   assign o_enc_marker = i_mark;
endmodule

// ### sim/testbench.sv
// Self-checking bench for the encoder window comparator
`timescale 1ns/10ps
module testbench;
   import ewc_pkg::*;
   logic i_mclk;
   logic i_rst_b;
   logic [3:0] up, dn, mk, enc_a, enc_b, enc_mk;
   logic [1:0] cfg_wr, cfg_en, cfg_half, win_in, win_en;
   logic [EWC_AXW-1:0] cfg_axis [EWC_NUM_WIN];
   logic signed [EWC_CW-1:0] cfg_load [EWC_NUM_WIN];
   logic signed [EWC_CW-1:0] cfg_low [EWC_NUM_WIN];
   logic signed [EWC_CW-1:0] cfg_high [EWC_NUM_WIN];
   logic signed [EWC_CW-1:0] win_count [EWC_NUM_WIN];
   logic [EWC_TRIG_W-1:0] cfg_trig [EWC_NUM_WIN];
   logic sel_ret, sel_inc, incr, permit, hold;
   int n_errors = 0;
   int tests_run = 0;

   ewc_enc_model ewc_enc_model_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_step_up(up),
      .i_step_dn(dn), .i_mark(mk), .o_enc_a(enc_a), .o_enc_b(enc_b), .o_enc_marker(enc_mk));
   ewc_window_cmp ewc_window_cmp_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_enc_a(enc_a),
      .i_enc_b(enc_b), .i_enc_marker(enc_mk), .i_cfg_wr(cfg_wr), .i_cfg_axis(cfg_axis),
      .i_cfg_load(cfg_load), .i_cfg_low(cfg_low), .i_cfg_high(cfg_high),
      .i_cfg_enable(cfg_en), .i_cfg_half_resolution_decode(cfg_half),
      .i_cfg_trigger(cfg_trig), .i_sel_position_retaining_gating(sel_ret),
      .i_sel_incremental_gating(sel_inc), .o_win_count(win_count), .o_win_inside(win_in),
      .o_win_enabled(win_en), .o_incremental_gating(incr), .o_fire_permit(permit),
      .o_fire_cnt_hold(hold));

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Outputs settle within four edges of any request
   task automatic settle();
      repeat (4) @(posedge i_mclk);
      #1;
   endtask

   task automatic cfg(input int w, input logic [1:0] ax, input logic [31:0] ld, lo, hi,
                      input logic en, hf, input logic [3:0] tr);
      @(posedge i_mclk);
      cfg_wr[w] <= 1'b1;
      cfg_axis[w] <= ax;
      cfg_load[w] <= ld;
      cfg_low[w] <= lo;
      cfg_high[w] <= hi;
      cfg_en[w] <= en;
      cfg_half[w] <= hf;
      cfg_trig[w] <= tr;
      @(posedge i_mclk);
      cfg_wr[w] <= 1'b0;
      settle();
   endtask

   task automatic step(input int ax, input logic u, input int n);
      repeat (n) begin
         @(posedge i_mclk);
         up[ax] <= u;
         dn[ax] <= !u;
         @(posedge i_mclk);
         up[ax] <= 1'b0;
         dn[ax] <= 1'b0;
         @(posedge i_mclk);
      end
      settle();
   endtask

   task automatic mark(input int ax);
      @(posedge i_mclk);
      mk[ax] <= 1'b1;
      repeat (2) @(posedge i_mclk);
      mk[ax] <= 1'b0;
      settle();
   endtask

   task automatic sel(input logic inc);
      @(posedge i_mclk);
      sel_inc <= inc;
      sel_ret <= !inc;
      @(posedge i_mclk);
      sel_inc <= 1'b0;
      sel_ret <= 1'b0;
      settle();
   endtask

   initial begin
      repeat (100000) @(posedge i_mclk);
      n_errors++;
      close_out();
   end

   initial begin
      i_rst_b = 1'b0;
      up = 4'h0;
      dn = 4'h0;
      mk = 4'h0;
      cfg_wr = 2'h0;
      cfg_en = 2'h0;
      cfg_half = 2'h0;
      sel_ret = 1'b0;
      sel_inc = 1'b0;
      for (int w = 0; w < EWC_NUM_WIN; w++) begin
         cfg_axis[w] = 2'h0;
         cfg_load[w] = 32'h0;
         cfg_low[w] = 32'h0;
         cfg_high[w] = 32'h0;
         cfg_trig[w] = 4'h0;
      end
      repeat (10) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      settle();
      check("enabled", win_en, 2'h0);
      check("gating", incr, 1'b0);
      check("permit", permit, 1'b1);
      cfg(0, 1, 5, 4, 8, 1, 0, 4'h0);
      check("count0", win_count[0], 32'h5);
      check("inside", win_in, 2'h1);
      step(1, 1, 3);
      check("count0", win_count[0], 32'h8);
      check("inside", win_in, 2'h0);
      check("permit", permit, 1'b0);
      step(1, 0, 1);
      check("inside", win_in, 2'h1);
      cfg(1, 2, -3, -5, -1, 1, 0, 4'h0);
      check("inside", win_in, 2'h3);
      check("permit", permit, 1'b1);
      step(2, 0, 2);
      check("count1", win_count[1], 32'hFFFF_FFFB);
      check("permit", permit, 1'b0);
      cfg(1, 2, -5, -5, -1, 0, 0, 4'h0);
      check("permit", permit, 1'b1);
      sel(1);
      check("gating", incr, 1'b1);
      step(1, 1, 1);
      check("hold", hold, 1'b1);
      step(1, 0, 1);
      check("hold", hold, 1'b0);
      step(1, 1, 1);
      sel(0);
      check("hold", hold, 1'b0);
      cfg(0, 3, 7, 4, 8, 1, 1, 4'h0);
      check("count0", win_count[0], 32'h3);
      step(3, 1, 4);
      check("count0", win_count[0], 32'h5);
      cfg(1, 0, 32'h7FFF_FFFF, 0, 0, 0, 0, 4'h0);
      check("count1", win_count[1], 32'h7FFF_FFFF);
      cfg(1, 0, 32'h8000_0000, 0, 0, 0, 1, 4'h0);
      check("count1", win_count[1], 32'hC000_0000);
      for (int m = 0; m < 4; m++) begin
         cfg(0, 1, 5, -1, 8, 1, 0, m[3:0]);
         mark(1);
         check("count0", win_count[0], (m == 1 || m == 2) ? 32'h0 : 32'h5);
         check("permit", permit, m != 1);
      end
      step(1, 1, 1);
      check("count0", win_count[0], 32'h6);
      cfg(0, 1, 5, -1, 8, 1, 0, 4'h4);
      cfg(0, 1, 5, -1, 8, 1, 0, 4'h1);
      mark(1);
      step(1, 1, 2);
      check("count0", win_count[0], 32'h2);
      check("permit", permit, 1'b1);
      close_out();
   end
endmodule
